// >>> verilog/epu_core.sv
// Exception, interrupt acceptance and priority unit of the CPU.
// Assumes a pipeline that presents one instruction per cycle only while busy is low,
// and an AHB-Lite master on the same clock.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "epu_cfg.svh"

module epu_core #(
  parameter int NUM_IRQ = 8,
  parameter int NUM_EXT = 2
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  // Pipeline
  input  wire epu_pkg::epu_instr_s instr,
  input  wire logic                idleMode,
  output logic                     busy,
  output logic                     ackValid,
  output logic                     redirectValid,
  output logic [31:0]              redirectPc,
  output logic [31:0]              programStatusWord,
  // Request sources
  input  wire logic [NUM_IRQ-1:0]  intReq,
  input  wire logic [NUM_EXT-1:0]  externalIntPin,
  input  wire logic                nmiPin
);
  localparam int IDX_W = $clog2(NUM_IRQ);

  epu_pkg::epu_state_e state;
  epu_pkg::epu_take_e  takeKind;
  logic [2:0]          icPri [NUM_IRQ];
  logic [NUM_IRQ-1:0]  icMask;
  logic [NUM_IRQ-1:0]  icFlag;
  logic [NUM_IRQ-1:0]  setVec;
  logic [NUM_EXT-1:0]  extSync1;
  logic [NUM_EXT-1:0]  extSync2;
  logic [NUM_EXT-1:0]  extPrev;
  logic                nmiSync1;
  logic                nmiSync2;
  logic                nmiPrev;
  logic                nmiPend;
  logic [7:0]          inService;
  logic [3:0]          curLevel;
  logic [2:0]          qualCnt;
  logic                candValid;
  logic [IDX_W-1:0]    candIdx;
  logic [2:0]          candPri;
  logic [31:0]         savedPc;
  logic [31:0]         savedPsw;
  logic [31:0]         nmiPc;
  logic [31:0]         nmiPsw;
  logic [31:0]         cause;
  logic [15:0]         takeCode;
  logic [31:0]         takeVec;
  logic [31:0]         takePc;
  logic [31:0]         retiPc;
  logic [31:0]         retiPsw;
  logic                stIdle;
  logic                takeNmi;
  logic                takeInt;
  logic                takeTrap;
  logic                takeIlg;
  logic                anyTake;
  logic                exec;
  logic                nonSample;
  logic                isIlg;
  logic                dWrite;
  logic                icAccess;
  logic [9:0]          dIdx;
  logic [9:0]          aIdx;
  logic                aPhase;
  logic [31:0]         rdMux;
  logic [31:0]         program_status_word;

  assign program_status_word = programStatusWord;

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  // Two flops double as the two-clock noise filter delay
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      extSync1 <= '0;
      extSync2 <= '0;
      extPrev  <= '0;
      nmiSync1 <= 1'b0;
      nmiSync2 <= 1'b0;
      nmiPrev  <= 1'b0;
    end else begin
      extSync1 <= externalIntPin;
      extSync2 <= extSync1;
      extPrev  <= extSync2;
      nmiSync1 <= nmiPin;
      nmiSync2 <= nmiSync1;
      nmiPrev  <= nmiSync2;
    end
  end

  always_comb begin
    setVec = intReq;
    setVec[NUM_EXT-1:0] = intReq[NUM_EXT-1:0] | (extSync2 & ~extPrev);
  end

  // NMI waits while its own routine runs; set wins over take
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nmiPend <= 1'b0;
    end else begin
      nmiPend <= (nmiPend & ~takeNmi) | (nmiSync2 & ~nmiPrev);
    end
  end

  // ----------------------------------------
  // Candidate selection and decision
  // ----------------------------------------
  always_comb begin
    candValid = 1'b0;
    candIdx   = '0;
    candPri   = 3'h7;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (icFlag[i] && !icMask[i] && (!candValid || icPri[i] < candPri)) begin
        candValid = 1'b1;
        candIdx   = IDX_W'(i);
        candPri   = icPri[i];
      end
    end
  end

  always_comb begin
    curLevel = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (inService[i]) begin
        curLevel = 4'(i);
      end
    end
  end

  assign stIdle  = (state == epu_pkg::ST_IDLE);
  assign isIlg   = (instr.word[10:5] == `EPU_ILG_SUB) && (instr.word[26:23] >= `EPU_ILG_LO);
  assign takeNmi = stIdle && nmiPend && !program_status_word[`EPU_PSW_NP];
  assign takeInt = stIdle && !takeNmi && candValid
                 && ({1'b0, candPri} < curLevel)
                 && !program_status_word[`EPU_PSW_ID]
                 && !program_status_word[`EPU_PSW_NP]
                 && (qualCnt == `EPU_QUAL_CYC);
  assign takeTrap = stIdle && !takeNmi && !takeInt && instr.valid
                  && (instr.op == epu_pkg::EPU_OP_TRAP);
  assign takeIlg  = stIdle && !takeNmi && !takeInt && instr.valid
                  && (instr.op != epu_pkg::EPU_OP_TRAP) && isIlg;
  assign anyTake  = takeNmi | takeInt | takeTrap | takeIlg;
  assign exec     = stIdle && instr.valid && !anyTake;
  assign nonSample = exec && ((instr.op == epu_pkg::EPU_OP_EI) || (instr.op == epu_pkg::EPU_OP_DI)
                   || ((instr.op == epu_pkg::EPU_OP_LOAD_SYSTEM_REGISTER_INSTR) && (instr.sysId == `EPU_SR_PSW)));

  // Window of clean enabled cycles before a maskable acknowledge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      qualCnt <= 3'h0;
    end else if (!stIdle || program_status_word[`EPU_PSW_ID] || nonSample
                 || (|setVec)
                 || idleMode || icAccess) begin
      qualCnt <= 3'h0;
    end else if (qualCnt != `EPU_QUAL_CYC) begin
      qualCnt <= qualCnt + 3'h1;
    end
  end

  // ----------------------------------------
  // Acceptance sequence
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state    <= epu_pkg::ST_IDLE;
      ackValid <= 1'b0;
      busy     <= 1'b0;
    end else begin
      ackValid <= anyTake;
      busy     <= stIdle ? anyTake : (state != epu_pkg::ST_VECTOR);
      unique case (state)
        epu_pkg::ST_IDLE:    state <= anyTake ? epu_pkg::ST_SAVEPC : epu_pkg::ST_IDLE;
        epu_pkg::ST_SAVEPC:  state <= epu_pkg::ST_SAVEPSW;
        epu_pkg::ST_SAVEPSW: state <= epu_pkg::ST_CODE;
        epu_pkg::ST_CODE:    state <= epu_pkg::ST_VECTOR;
        epu_pkg::ST_VECTOR:  state <= epu_pkg::ST_IDLE;
        default:             state <= epu_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      takeKind <= epu_pkg::TK_NMI;
      takeCode <= 16'h0000;
      takeVec  <= 32'h0000_0000;
      takePc   <= 32'h0000_0000;
    end else if (takeNmi) begin
      takeKind <= epu_pkg::TK_NMI;
      takeCode <= `EPU_CODE_NMI;
      takeVec  <= `EPU_VEC_NMI;
      takePc   <= instr.pc;
    end else if (takeInt) begin
      takeKind <= epu_pkg::TK_INT;
      takeCode <= `EPU_CODE_INT + 16'({candIdx, 4'h0});
      takeVec  <= `EPU_VEC_INT + 32'({candIdx, 4'h0});
      takePc   <= instr.pc;
    end else if (takeTrap) begin
      takeKind <= epu_pkg::TK_TRAP;
      takeCode <= `EPU_CODE_TRAP + 16'(instr.data[4:0]);
      takeVec  <= instr.data[4] ? `EPU_VEC_TRAP1 : `EPU_VEC_TRAP0;
      takePc   <= instr.pc + 32'h0000_0004;
    end else if (takeIlg) begin
      takeKind <= epu_pkg::TK_ILG;
      takeCode <= `EPU_CODE_ILLEGAL_OPCODE_TRAP;
      takeVec  <= `EPU_VEC_ILLEGAL_OPCODE_TRAP;
      takePc   <= instr.pc + 32'h0000_0004;
    end
  end

  // ----------------------------------------
  // Save registers and cause
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      savedPc  <= 32'h0000_0000;
      savedPsw <= 32'h0000_0000;
      nmiPc    <= 32'h0000_0000;
      nmiPsw   <= 32'h0000_0000;
      cause    <= 32'h0000_0000;
    end else if (state == epu_pkg::ST_SAVEPC) begin
      if (takeKind == epu_pkg::TK_NMI) nmiPc <= takePc;
      else savedPc <= takePc;
    end else if (state == epu_pkg::ST_SAVEPSW) begin
      if (takeKind == epu_pkg::TK_NMI) nmiPsw <= program_status_word;
      else savedPsw <= program_status_word;
    end else if (state == epu_pkg::ST_CODE) begin
      if (takeKind == epu_pkg::TK_NMI) cause[31:16] <= takeCode;
      else cause[15:0] <= takeCode;
    end else if (exec && instr.op == epu_pkg::EPU_OP_LOAD_SYSTEM_REGISTER_INSTR) begin
      if (instr.sysId == `EPU_SR_SAVED_RETURN_PC) savedPc <= instr.data;
      if (instr.sysId == `EPU_SR_SAVED_STATUS_WORD) savedPsw <= instr.data;
    end
  end

  // Return source follows the flags, so software must restore them first
  always_comb begin
    if (program_status_word[`EPU_PSW_EP] || !program_status_word[`EPU_PSW_NP]) begin
      retiPc  = savedPc;
      retiPsw = savedPsw;
    end else begin
      retiPc  = nmiPc;
      retiPsw = nmiPsw;
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      programStatusWord <= `EPU_PSW_RESET;
    end else if (state == epu_pkg::ST_CODE) begin
      programStatusWord[`EPU_PSW_ID] <= 1'b1;
      if (takeKind == epu_pkg::TK_TRAP || takeKind == epu_pkg::TK_ILG) begin
        programStatusWord[`EPU_PSW_EP] <= 1'b1;
      end
      if (takeKind == epu_pkg::TK_NMI) programStatusWord[`EPU_PSW_NP] <= 1'b1;
    end else if (exec) begin
      unique case (instr.op)
        epu_pkg::EPU_OP_EI:   programStatusWord[`EPU_PSW_ID] <= 1'b0;
        epu_pkg::EPU_OP_DI:   programStatusWord[`EPU_PSW_ID] <= 1'b1;
        epu_pkg::EPU_OP_RETURN_FROM_EXCEPTION: programStatusWord <= retiPsw;
        epu_pkg::EPU_OP_LOAD_SYSTEM_REGISTER_INSTR: begin
          if (instr.sysId == `EPU_SR_PSW) programStatusWord <= instr.data;
        end
        epu_pkg::EPU_OP_NONE, epu_pkg::EPU_OP_TRAP: begin
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Redirect to handler or restored address
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      redirectValid <= 1'b0;
      redirectPc    <= 32'h0000_0000;
    end else if (state == epu_pkg::ST_VECTOR) begin
      redirectValid <= 1'b1;
      redirectPc    <= takeVec;
    end else if (exec && instr.op == epu_pkg::EPU_OP_RETURN_FROM_EXCEPTION) begin
      redirectValid <= 1'b1;
      redirectPc    <= retiPc;
    end else begin
      redirectValid <= 1'b0;
    end
  end

  // Levels in service; a return from a maskable routine pops the highest
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      inService <= 8'h00;
    end else if (takeInt) begin
      inService[candPri] <= 1'b1;
    end else if (exec && instr.op == epu_pkg::EPU_OP_RETURN_FROM_EXCEPTION && !program_status_word[`EPU_PSW_EP]
                 && !program_status_word[`EPU_PSW_NP] && !curLevel[3]) begin
      inService[curLevel[2:0]] <= 1'b0;
    end
  end

  // ----------------------------------------
  // Request control registers
  // ----------------------------------------
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_IRQ; i++) icPri[i] <= `EPU_IC_PRI_RESET;
      icMask <= '1;
      icFlag <= '0;
    end else begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        if (dWrite && dIdx == `EPU_IDX_IC + 10'(i)) begin
          icPri[i]  <= hwdata[2:0];
          icMask[i] <= hwdata[`EPU_IC_MK];
          icFlag[i] <= hwdata[`EPU_IC_IF] | setVec[i];
        end else begin
          icFlag[i] <= (icFlag[i] & ~(takeInt && candIdx == IDX_W'(i))) | setVec[i];
        end
      end
    end
  end

  // ----------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------
  assign aPhase = hsel && htrans[1] && hready;
  assign aIdx   = haddr[11:2];

  always_comb begin
    rdMux = 32'h0000_0000;
    if (aIdx < `EPU_IDX_IC + 10'(NUM_IRQ)) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        if (aIdx == `EPU_IDX_IC + 10'(i)) begin
          rdMux = {24'h00_0000, icFlag[i], icMask[i], 3'h0, icPri[i]};
        end
      end
    end else begin
      unique case (aIdx)
        `EPU_IDX_PSW:   rdMux = program_status_word;
        `EPU_IDX_SAVED_RETURN_PC:  rdMux = savedPc;
        `EPU_IDX_SAVED_STATUS_WORD: rdMux = savedPsw;
        `EPU_IDX_ECR:   rdMux = cause;
        `EPU_IDX_INSVC: rdMux = {24'h00_0000, inService};
        default:        rdMux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dWrite    <= 1'b0;
      dIdx      <= 10'h000;
      icAccess  <= 1'b0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dWrite    <= aPhase && hwrite;
      dIdx      <= aIdx;
      icAccess  <= aPhase && (aIdx < `EPU_IDX_IC + 10'(NUM_IRQ));
      hrdata    <= (aPhase && !hwrite) ? rdMux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence sSteps;
    state == epu_pkg::ST_SAVEPC ##1 state == epu_pkg::ST_SAVEPSW
      ##1 state == epu_pkg::ST_CODE ##1 state == epu_pkg::ST_VECTOR;
  endsequence

  sequence sIlgDone;
    ##4 (redirectValid && redirectPc == `EPU_VEC_ILLEGAL_OPCODE_TRAP);
  endsequence

  AST_SAVE_ORDER: assert property (ackValid |-> sSteps)
    else $error("acceptance steps out of order");
  AST_RUN_FOUR: assert property (ackValid |-> ##4 redirectValid)
    else $error("handler not started four clocks after acknowledge");
  AST_ILG_VECTOR: assert property (takeIlg |=> sIlgDone)
    else $error("illegal opcode handler address wrong");
  AST_ILG_CODE: assert property (state == epu_pkg::ST_CODE && takeKind == epu_pkg::TK_ILG |=> cause[15:0] == 16'h0060)
    else $error("illegal opcode cause code wrong");
  AST_EXC_FLAGS: assert property (takeIlg |=> ##3 (program_status_word[`EPU_PSW_EP] && program_status_word[`EPU_PSW_ID]))
    else $error("progress or disable flag not set on trap");
  AST_SAVED_PSW: assert property (state == epu_pkg::ST_SAVEPSW && takeKind != epu_pkg::TK_NMI |=> savedPsw == $past(program_status_word))
    else $error("status word not saved");
  AST_NMI_HOLD: assert property (program_status_word[`EPU_PSW_NP] && stIdle |=> !(ackValid && takeKind == epu_pkg::TK_INT))
    else $error("maskable taken inside NMI routine");
  AST_ID_GATE: assert property (ackValid && takeKind == epu_pkg::TK_INT |->
    !$past(program_status_word[`EPU_PSW_ID]) && $past({1'b0, candPri} < curLevel))
    else $error("maskable taken while disabled or not higher");
  AST_NONSAMPLE: assert property (nonSample |=> !takeInt)
    else $error("acknowledge right after non-sample instruction");
  AST_EI_SEVEN: assert property (exec && instr.op == epu_pkg::EPU_OP_EI |=> !takeInt [*7])
    else $error("acknowledge within seven clocks of enable");
  AST_RETURN_FROM_EXCEPTION: assert property (exec && instr.op == epu_pkg::EPU_OP_RETURN_FROM_EXCEPTION && program_status_word[`EPU_PSW_EP] |=> redirectPc == $past(savedPc) && program_status_word == $past(savedPsw))
    else $error("return did not restore saved state");
  AST_INT_SETS_ID: assert property (takeInt |=> ##3 program_status_word[`EPU_PSW_ID])
    else $error("disable flag not set on maskable acceptance");
endmodule : epu_core

// >>> verilog/epu_cfg.svh
// Constants of the exception and priority unit: offsets, fields, codes, timing.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef EPU_CFG_SVH
`define EPU_CFG_SVH
// ----------------------------------------
// Status word fields and reset value
// ----------------------------------------
`define EPU_PSW_ID        5
`define EPU_PSW_EP        6
`define EPU_PSW_NP        7
`define EPU_PSW_RESET     32'h0000_0020
// ----------------------------------------
// Cause codes and handler addresses
// ----------------------------------------
`define EPU_CODE_ILLEGAL_OPCODE_TRAP    16'h0060
`define EPU_VEC_ILLEGAL_OPCODE_TRAP     32'h0000_0060
`define EPU_CODE_NMI      16'h0010
`define EPU_VEC_NMI       32'h0000_0010
`define EPU_CODE_TRAP     16'h0040
`define EPU_VEC_TRAP0     32'h0000_0040
`define EPU_VEC_TRAP1     32'h0000_0050
`define EPU_CODE_INT      16'h0080
`define EPU_VEC_INT       32'h0000_0080
// ----------------------------------------
// Illegal opcode pattern
// ----------------------------------------
`define EPU_ILG_SUB       6'h3F
`define EPU_ILG_LO        4'h3
// ----------------------------------------
// System register numbers for the load instruction
// ----------------------------------------
`define EPU_SR_SAVED_RETURN_PC       5'h00
`define EPU_SR_SAVED_STATUS_WORD      5'h01
`define EPU_SR_PSW        5'h05
// ----------------------------------------
// Bus word indices (byte address / 4)
// ----------------------------------------
`define EPU_IDX_IC        10'h000
`define EPU_IDX_PSW       10'h040
`define EPU_IDX_SAVED_RETURN_PC      10'h041
`define EPU_IDX_SAVED_STATUS_WORD     10'h042
`define EPU_IDX_ECR       10'h043
`define EPU_IDX_INSVC     10'h044
// ----------------------------------------
// Request control register fields
// ----------------------------------------
`define EPU_IC_MK         6
`define EPU_IC_IF         7
`define EPU_IC_PRI_RESET  3'h7
// ----------------------------------------
// Timing
// ----------------------------------------
`define EPU_CLK_MHZ       100
`define EPU_QUAL_NS       70
`define EPU_QUAL_CYC      3'(((`EPU_QUAL_NS * `EPU_CLK_MHZ) + 999) / 1000)
`endif

// >>> verilog/epu_pkg.sv
// Types shared by the exception and priority unit.
// Assumes nothing of its surroundings.
package epu_pkg;
  typedef enum logic [2:0] {
    EPU_OP_NONE, EPU_OP_EI, EPU_OP_DI, EPU_OP_RETURN_FROM_EXCEPTION, EPU_OP_LOAD_SYSTEM_REGISTER_INSTR, EPU_OP_TRAP
  } epu_op_e;

  typedef struct packed {
    logic        valid;
    epu_op_e     op;
    logic [31:0] word;
    logic [31:0] pc;
    logic [4:0]  sysId;
    logic [31:0] data;
  } epu_instr_s;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b0_0001,
    ST_SAVEPC  = 5'b0_0010,
    ST_SAVEPSW = 5'b0_0100,
    ST_CODE    = 5'b0_1000,
    ST_VECTOR  = 5'b1_0000
  } epu_state_e;

  typedef enum logic [1:0] {TK_NMI, TK_INT, TK_TRAP, TK_ILG} epu_take_e;
endpackage : epu_pkg

// >>> bench/epu_src_model.sv
// Request-source model: turns bench commands into request pulses and pin edges.
// Assumes the bench clock; commands change just after a rising edge.
`timescale 1ns/1ns
module epu_src_model (
  // Clock
  input  wire logic       clk_sys,
  // Commands
  input  wire logic [7:0] fire,
  input  wire logic       fireNmi,
  // Requests
  output logic [7:0]      intReq,
  output logic            nmiPin
);
  logic [7:0] last;
  initial begin
    intReq = '0;
    nmiPin = 1'b0;
    last   = '0;
  end
  // A level request would re-raise the flag every cycle, so pulse once
  always @(posedge clk_sys) begin
    intReq <= fire & ~last;
    last   <= fire;
    nmiPin <= fireNmi;
  end
endmodule : epu_src_model

// >>> bench/cpu_exception_priority_unit_test.sv
// Self-checking bench of the exception and priority unit.
// Assumes the design package and config header; one clock, AHB-Lite single words.
`timescale 1ns/1ns
`include "epu_cfg.svh"
module cpu_exception_priority_unit_test;
  logic clk_sys, reset_n, hsel, hwrite, hreadyout, hresp, busy, ackValid, redirectValid, fireNmi, nmiPin;
  logic [31:0] haddr, hwdata, hrdata, redirectPc, programStatusWord, q;
  logic [1:0] htrans;
  logic [7:0] fire, intReq;
  logic [1:0] extPin;
  logic       idleMode;
  epu_pkg::epu_instr_s instr;
  int mismatches, checked, n, ackAt, busyN;
  logic [31:0] rw[4] = '{32'h0180_07E0, 32'h0780_07E0, 32'h0100_07E0, 32'h0180_07C0};
  logic rt[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  epu_core epu_core_i (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .instr(instr), .idleMode(idleMode), .busy(busy), .ackValid(ackValid),
    .redirectValid(redirectValid), .redirectPc(redirectPc), .programStatusWord(programStatusWord),
    .intReq(intReq), .externalIntPin(extPin), .nmiPin(nmiPin));
  epu_src_model epu_src_model_i (.clk_sys(clk_sys), .fire(fire), .fireNmi(fireNmi), .intReq(intReq),
    .nmiPin(nmiPin));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
    q = hrdata;
    hsel <= 1'b0;
    if (k >= 40) begin
      mismatches++;
      summarize();
    end
  endtask : ahb
  task automatic issue(input epu_pkg::epu_op_e op, input logic [31:0] w, input logic [31:0] pc);
    @(posedge clk_sys);
    instr <= '{1'b1, op, w, pc, 5'h00, 32'h0000_0000};
    @(posedge clk_sys);
    instr.valid <= 1'b0;
  endtask : issue
  // Counts edges up to a redirect; bound cuts a hang
  // Reads at the edge see the pulse while it still stands
  task automatic waitRedir(input int lim, input bit want);
    n     = 0;
    ackAt = 0;
    busyN = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (ackValid === 1'b1) ackAt = n;
      if (busy === 1'b1) busyN++;
    end while (redirectValid !== 1'b1 && n < lim);
    if (want && redirectValid !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %0t no redirect", $time);
      summarize();
    end
  endtask : waitRedir
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reset_n, hsel, hwrite, fireNmi, mismatches, checked} = '0;
    {haddr, hwdata, htrans, fire, extPin, idleMode} = '0;
    instr = '{1'b0, epu_pkg::EPU_OP_NONE, 32'h0, 32'h0000_1000, 5'h0, 32'h0};
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    chk(programStatusWord, `EPU_PSW_RESET);
    ahb(1'b0, 32'h0000_0000, 32'h0);
    chk(q[7:0], 8'h47);
    chk(32'(hresp), 32'h0);
    for (int i = 0; i < 4; i++) begin
      issue(epu_pkg::EPU_OP_NONE, rw[i], 32'h0000_1000 + 32'(i * 16));
      waitRedir(rt[i] ? 40 : 12, rt[i]);
      chk(32'(redirectValid), 32'(rt[i]));
      if (rt[i]) begin
        chk(32'(n - ackAt), 32'h4);
        chk(32'(busyN), 32'h4);
        chk(redirectPc, `EPU_VEC_ILLEGAL_OPCODE_TRAP);
        chk(programStatusWord, 32'h0000_0060);
        ahb(1'b0, 32'h0000_010C, 32'h0);
        chk(q[15:0], `EPU_CODE_ILLEGAL_OPCODE_TRAP);
        ahb(1'b0, 32'h0000_0104, 32'h0);
        chk(q, 32'h0000_1004 + 32'(i * 16));
        ahb(1'b0, 32'h0000_0108, 32'h0);
        chk(q, `EPU_PSW_RESET);
        issue(epu_pkg::EPU_OP_RETURN_FROM_EXCEPTION, 32'h0, 32'h0000_0060);
        waitRedir(10, 1'b1);
        chk(redirectPc, 32'h0000_1004 + 32'(i * 16));
        chk(programStatusWord, `EPU_PSW_RESET);
      end
    end
    ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
    issue(epu_pkg::EPU_OP_EI, 32'h0, 32'h0000_2000);
    @(posedge clk_sys);
    chk(programStatusWord, 32'h0);
    repeat (9) @(posedge clk_sys);
    fire <= 8'h01;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (intReq[0] !== 1'b1 && n < 5);
    fire <= 8'h00;
    waitRedir(40, 1'b1);
    chk(32'(n >= 11 && n <= 18), 32'h1);
    chk(redirectPc, `EPU_VEC_INT);
    chk(programStatusWord, `EPU_PSW_RESET);
    issue(epu_pkg::EPU_OP_RETURN_FROM_EXCEPTION, 32'h0, 32'h0000_0080);
    waitRedir(10, 1'b1);
    chk(programStatusWord, 32'h0);
    // Sleep holds a pin request until the window runs clean
    idleMode <= 1'b1;
    extPin   <= 2'h1;
    waitRedir(25, 1'b0);
    chk(32'(redirectValid), 32'h0);
    idleMode <= 1'b0;
    waitRedir(40, 1'b1);
    chk(32'(n >= 7 + 4), 32'h1);
    issue(epu_pkg::EPU_OP_RETURN_FROM_EXCEPTION, 32'h0, 32'h0000_0080);
    waitRedir(10, 1'b1);
    extPin <= 2'h0;
    repeat (4) @(posedge clk_sys);
    extPin <= 2'h1;
    waitRedir(40, 1'b1);
    chk(32'(n >= 13 && n <= 20), 32'h1);
    chk(redirectPc, `EPU_VEC_INT);
    issue(epu_pkg::EPU_OP_RETURN_FROM_EXCEPTION, 32'h0, 32'h0000_0080);
    waitRedir(10, 1'b1);
    chk(programStatusWord, 32'h0);
    issue(epu_pkg::EPU_OP_DI, 32'h0, 32'h0000_2004);
    fire <= 8'h01;
    @(posedge clk_sys);
    fire <= 8'h00;
    waitRedir(20, 1'b0);
    chk(32'(redirectValid), 32'h0);
    issue(epu_pkg::EPU_OP_EI, 32'h0, 32'h0000_2008);
    waitRedir(40, 1'b1);
    chk(32'(n >= 7 + 4), 32'h1);
    chk(redirectPc, `EPU_VEC_INT);
    fireNmi <= 1'b1;
    waitRedir(40, 1'b1);
    fireNmi <= 1'b0;
    chk(redirectPc, `EPU_VEC_NMI);
    chk(programStatusWord[`EPU_PSW_NP], 1'b1);
    // Trap with an illegal word: trap outranks the illegal opcode
    issue(epu_pkg::EPU_OP_TRAP, rw[0], 32'h0000_3000);
    waitRedir(20, 1'b1);
    chk(redirectPc, `EPU_VEC_TRAP0);
    summarize();
  end
endmodule : cpu_exception_priority_unit_test
